/* File: hw/pci_agent.sv */
// Agent end of the bus: single-word initiator and four-word target,
// with parity drive and check, address parity report and interrupt.
// Assumes the host end keeps its own bus obligations.
`timescale 1ns/100ps
`default_nettype none
module pci_agent (
  pci_link_if.dev_end      bus,
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        irq_req,
  input  wire logic        mreq,
  input  wire logic        mwrite,
  input  wire pci_pkg::word_t maddr,
  input  wire pci_pkg::word_t mwdata,
  input  wire logic [3:0]  mbe,
  output logic             mbusy,
  output logic             mdone_r,
  output logic             merr_r,
  output pci_pkg::word_t   mrdata_r,
  output logic             par_err_r
);
  import pci_pkg::*;

  typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA, M_TURN} mst_t;
  typedef enum logic [1:0] {T_IDLE, T_DATA, T_STOP, T_TURN} tgt_t;

  mst_t        m_st;
  tgt_t        t_st;
  logic        m_wr_r, t_wr_r, t_rdy_r, t_stop_r, frame_q_r;
  word_t       m_wdata_r;
  logic [3:0]  m_be_r;
  logic [2:0]  m_cnt_r;
  logic [1:0]  t_idx_r, rd_idx;
  word_t [3:0] mem_r;
  word_t       ad_r;
  logic [3:0]  cbe_r;
  logic        ad_oe_r, par_r, par_oe_r, chk_r, ap_q_r, dp_q_r;
  logic        perr_r, perr_hi_r, serr_r, inta_r;
  logic        addr_ph, hit, xfer, m_go, m_end, t_end;

  // Address phase is the first clock with frame asserted
  assign addr_ph = !bus.frame_n && frame_q_r;
  assign hit     = addr_ph && m_st == M_IDLE && bus.ad[31:4] == DEV_WIN
                   && (bus.cbe == CMD_MEM_RD || bus.cbe == CMD_MEM_WR);
  assign xfer    = !bus.irdy_n && !bus.trdy_n;
  assign m_go    = m_st == M_IDLE && mreq && t_st == T_IDLE && bus.frame_n && bus.irdy_n
                   && frame_q_r;
  assign m_end   = m_st == M_DATA && (!bus.trdy_n || !bus.stop_n
                   || (bus.devsel_n && m_cnt_r == MABORT_CYC));
  assign t_end   = t_st == T_DATA && t_rdy_r && xfer && (bus.frame_n || t_stop_r);
  assign rd_idx  = t_rdy_r ? t_idx_r + 2'h1 : t_idx_r;
  assign mbusy   = m_st != M_IDLE;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) frame_q_r <= 1'b1;
    else frame_q_r <= bus.frame_n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Initiator: one data phase per transaction
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      m_st <= M_IDLE; m_wr_r <= 1'b0; m_wdata_r <= '0; m_be_r <= 4'hf;
      m_cnt_r <= 3'h0; mdone_r <= 1'b0; merr_r <= 1'b0; mrdata_r <= '0;
    end else begin
      mdone_r <= 1'b0;
      unique case (m_st)
        M_IDLE: if (m_go) begin
          m_st <= M_ADDR; m_wr_r <= mwrite; m_wdata_r <= mwdata; m_be_r <= mbe;
          merr_r <= 1'b0;
        end
        M_ADDR: begin
          m_st <= M_DATA; m_cnt_r <= 3'h0;
        end
        M_DATA: begin
          if (bus.devsel_n) m_cnt_r <= m_cnt_r + 3'h1;
          // Wait cycles until the target is ready too
          if (xfer && !m_wr_r) mrdata_r <= bus.ad;
          if (m_end) begin
            m_st <= M_TURN; mdone_r <= 1'b1; merr_r <= !xfer;
          end
        end
        M_TURN: m_st <= M_IDLE;
      endcase
    end
  end

  assign bus.dev_frame_oe = m_st == M_ADDR || m_st == M_DATA;
  assign bus.dev_frame_o  = m_st != M_ADDR;
  assign bus.dev_irdy_oe  = m_st == M_DATA || m_st == M_TURN;
  // Write data is already on the bus; reads are always accepted
  assign bus.dev_irdy_o   = m_st != M_DATA;
  assign bus.dev_cbe_oe   = m_st == M_ADDR || m_st == M_DATA;
  assign bus.dev_cbe_o    = cbe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Target: burst into four words, disconnect with stop on the last
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      t_st <= T_IDLE; t_wr_r <= 1'b0; t_idx_r <= 2'h0; t_rdy_r <= 1'b0;
      t_stop_r <= 1'b0;
    end else begin
      unique case (t_st)
        T_IDLE: if (hit) begin
          t_st <= T_DATA; t_wr_r <= bus.cbe[0]; t_idx_r <= bus.ad[3:2];
          t_rdy_r <= bus.cbe[0];
          t_stop_r <= bus.cbe[0] && bus.ad[3:2] == LAST_IDX;
        end
        T_DATA: begin
          if (!t_rdy_r) begin
            // Read turnaround done, data now on the bus
            t_rdy_r <= 1'b1; t_stop_r <= t_idx_r == LAST_IDX;
          end else if (xfer) begin
            t_idx_r <= t_idx_r + 2'h1; t_stop_r <= t_idx_r + 2'h1 == LAST_IDX;
          end
          if (t_end) begin
            t_rdy_r <= 1'b0;
            t_st <= bus.frame_n ? T_TURN : T_STOP;
          end
        end
        // Hold devsel until the master drops frame; stop is already released here, t_stop_r cleared with the last transfer
        T_STOP: if (bus.frame_n) t_st <= T_TURN;
        T_TURN: begin
          t_st <= T_IDLE; t_stop_r <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) mem_r <= '0;
    else if (t_st == T_DATA && t_wr_r && xfer) begin
      for (int b = 0; b < 4; b++)
        if (!bus.cbe[b]) mem_r[t_idx_r][8*b +: 8] <= bus.ad[8*b +: 8];
    end
  end

  assign bus.dev_devsel_oe = t_st != T_IDLE;
  assign bus.dev_devsel_o  = t_st == T_TURN;
  assign bus.dev_trdy_oe   = t_st != T_IDLE;
  assign bus.dev_trdy_o    = !(t_st == T_DATA && t_rdy_r);
  assign bus.dev_stop_oe   = t_st != T_IDLE;
  assign bus.dev_stop_o    = !(t_stop_r && (t_st == T_DATA || t_st == T_STOP));

  ////////////////////////////////////////////////////////////////////////////
  // Address/data and command drive
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ad_r <= '0; ad_oe_r <= 1'b0; cbe_r <= 4'hf;
    end else if (m_go) begin
      ad_r <= maddr; ad_oe_r <= 1'b1;
      cbe_r <= mwrite ? CMD_MEM_WR : CMD_MEM_RD;
    end else if (m_st == M_ADDR) begin
      ad_r <= m_wdata_r; ad_oe_r <= m_wr_r; cbe_r <= m_be_r;
    end else if (m_st == M_DATA) begin
      if (m_end) ad_oe_r <= 1'b0;
    end else if (t_st == T_DATA && !t_wr_r) begin
      if (t_end) ad_oe_r <= 1'b0;
      else if (!t_rdy_r || (xfer && !t_stop_r)) begin
        ad_r <= mem_r[rd_idx]; ad_oe_r <= 1'b1;
      end
    end else begin
      ad_oe_r <= 1'b0;
    end
  end
  assign bus.dev_ad_o  = ad_r;
  assign bus.dev_ad_oe = ad_oe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Parity: driven one clock behind each clock in which this end drove address/data
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      par_r <= 1'b0; par_oe_r <= 1'b0;
    end else begin
      par_r    <= even_par(bus.ad, bus.cbe);
      par_oe_r <= ad_oe_r || m_st == M_ADDR;
    end
  end
  assign bus.dev_par_o  = par_r;
  assign bus.dev_par_oe = par_oe_r;

  // Check received parity against the bits of the clock before
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      chk_r <= 1'b0; ap_q_r <= 1'b0; dp_q_r <= 1'b0; perr_r <= 1'b0;
      perr_hi_r <= 1'b0; serr_r <= 1'b0; par_err_r <= 1'b0;
    end else begin
      chk_r     <= even_par(bus.ad, bus.cbe);
      ap_q_r    <= addr_ph && !ad_oe_r;
      dp_q_r    <= xfer && !ad_oe_r && ((t_st == T_DATA && t_wr_r)
                   || (m_st == M_DATA && !m_wr_r));
      perr_r    <= dp_q_r && bus.par != chk_r;
      perr_hi_r <= perr_r;
      serr_r    <= ap_q_r && bus.par != chk_r;
      par_err_r <= (dp_q_r || ap_q_r) && bus.par != chk_r;
    end
  end
  assign bus.dev_perr_oe = perr_r || perr_hi_r;
  assign bus.dev_perr_o  = !perr_r;
  assign bus.dev_serr_oe = serr_r;
  assign bus.dev_serr_o  = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt, open drain
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) inta_r <= 1'b0;
    else inta_r <= irq_req;
  end
  assign bus.dev_inta_oe = inta_r;
  assign bus.dev_inta_o  = 1'b0;
endmodule
`default_nettype wire

/* File: hw/pci_pkg.sv */
// Shared constants, bus commands and parity helper for both bus ends.
// Assumes a single bus clock and active-low bus signals as in PCI.
package pci_pkg;

  typedef logic [31:0] word_t;

  localparam logic [3:0]  CMD_MEM_RD = 4'h6;
  localparam logic [3:0]  CMD_MEM_WR = 4'h7;
  // Claim windows, compared against address bits 31:4
  localparam logic [27:0] DEV_WIN    = 28'h0001000;
  localparam logic [27:0] HOST_WIN   = 28'h0002000;
  // Clocks without device select before a master abort
  localparam logic [2:0]  MABORT_CYC = 3'h5;
  // Last word index of a four-word store
  localparam logic [1:0]  LAST_IDX   = 2'h3;

  // Even parity bit over address/data and command/byte enables
  function automatic logic even_par(input logic [31:0] ad, input logic [3:0] cbe);
    return ^{ad, cbe};
  endfunction

endpackage

/* File: hw/pci_link_if.sv */
// Bus wires between the agent end and the host end.
// Each party gives value and enable; the wire level is resolved here,
// sustained and open-drain lines float high when nobody drives.
`timescale 1ns/100ps
`default_nettype none
interface pci_link_if;
  logic [31:0] ad;
  logic [3:0]  cbe;
  logic        par, frame_n, irdy_n, trdy_n, devsel_n, stop_n, perr_n, serr_n, inta_n;

  logic [31:0] dev_ad_o, host_ad_o;
  logic [3:0]  dev_cbe_o, host_cbe_o;
  logic        dev_ad_oe, dev_cbe_oe, host_ad_oe, host_cbe_oe;
  logic        dev_par_o, dev_par_oe, host_par_o, host_par_oe;
  logic        dev_frame_o, dev_frame_oe, host_frame_o, host_frame_oe;
  logic        dev_irdy_o, dev_irdy_oe, host_irdy_o, host_irdy_oe;
  logic        dev_trdy_o, dev_trdy_oe, host_trdy_o, host_trdy_oe;
  logic        dev_devsel_o, dev_devsel_oe, host_devsel_o, host_devsel_oe;
  logic        dev_stop_o, dev_stop_oe, host_stop_o, host_stop_oe;
  logic        dev_perr_o, dev_perr_oe, host_perr_o, host_perr_oe;
  logic        dev_serr_o, dev_serr_oe, dev_inta_o, dev_inta_oe;

  assign ad       = dev_ad_oe ? dev_ad_o : host_ad_oe ? host_ad_o : 32'h0;
  assign cbe      = dev_cbe_oe ? dev_cbe_o : host_cbe_oe ? host_cbe_o : 4'hf;
  assign par      = dev_par_oe ? dev_par_o : host_par_oe ? host_par_o : 1'b0;
  assign frame_n  = dev_frame_oe ? dev_frame_o : host_frame_oe ? host_frame_o : 1'b1;
  assign irdy_n   = dev_irdy_oe ? dev_irdy_o : host_irdy_oe ? host_irdy_o : 1'b1;
  assign trdy_n   = dev_trdy_oe ? dev_trdy_o : host_trdy_oe ? host_trdy_o : 1'b1;
  assign devsel_n = dev_devsel_oe ? dev_devsel_o : host_devsel_oe ? host_devsel_o : 1'b1;
  assign stop_n   = dev_stop_oe ? dev_stop_o : host_stop_oe ? host_stop_o : 1'b1;
  assign perr_n   = dev_perr_oe ? dev_perr_o : host_perr_oe ? host_perr_o : 1'b1;
  assign serr_n   = dev_serr_oe ? dev_serr_o : 1'b1;
  assign inta_n   = dev_inta_oe ? dev_inta_o : 1'b1;

  modport dev_end (
    input  ad, cbe, par, frame_n, irdy_n, trdy_n, devsel_n, stop_n, perr_n, serr_n, inta_n,
    output dev_ad_o, dev_ad_oe, dev_cbe_o, dev_cbe_oe, dev_par_o, dev_par_oe,
    output dev_frame_o, dev_frame_oe, dev_irdy_o, dev_irdy_oe, dev_trdy_o, dev_trdy_oe,
    output dev_devsel_o, dev_devsel_oe, dev_stop_o, dev_stop_oe, dev_perr_o, dev_perr_oe,
    output dev_serr_o, dev_serr_oe, dev_inta_o, dev_inta_oe
  );
  modport host_end (
    input  ad, cbe, par, frame_n, irdy_n, trdy_n, devsel_n, stop_n, perr_n, serr_n, inta_n,
    output host_ad_o, host_ad_oe, host_cbe_o, host_cbe_oe, host_par_o, host_par_oe,
    output host_frame_o, host_frame_oe, host_irdy_o, host_irdy_oe, host_trdy_o, host_trdy_oe,
    output host_devsel_o, host_devsel_oe, host_stop_o, host_stop_oe, host_perr_o, host_perr_oe
  );
endinterface
`default_nettype wire

/* File: hw/pci_host.sv */
// Host end: burst initiator into the agent and a four-word target.
// Assumes the agent end keeps its own bus obligations.
`timescale 1ns/100ps
`default_nettype none
module pci_host (
  pci_link_if.host_end     bus,
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        go,
  input  wire logic        write,
  input  wire pci_pkg::word_t addr,
  input  wire logic [1:0]  len,
  input  wire pci_pkg::word_t [3:0] wdata,
  input  wire logic [3:0]  be,
  output logic             busy,
  output logic             done_p,
  output logic             err_r,
  output logic [2:0]       nwords_r,
  output pci_pkg::word_t [3:0] rdata_r,
  output logic             irq_seen,
  output logic             serr_seen,
  output logic             perr_seen
);
  import pci_pkg::*;

  typedef enum logic [1:0] {M_IDLE, M_ADDR, M_DATA, M_TURN} mst_t;
  typedef enum logic [1:0] {T_IDLE, T_DATA, T_TURN} tgt_t;

  mst_t        m_st;
  tgt_t        t_st;
  logic        m_wr_r, t_wr_r, frame_q_r, t_rdy_r;
  logic [1:0]  m_left_r, m_idx_r, t_idx_r;
  logic [2:0]  m_cnt_r;
  word_t       ad_r;
  logic        ad_oe_r, par_r, par_oe_r, chk_r, dp_q_r, perr_r, perr_hi_r;
  logic [3:0]  cbe_r;
  word_t [3:0] mem_r;
  logic        addr_ph, hit, xfer, m_go, m_end, t_last;
  logic [1:0]  rd_idx;

  assign addr_ph = !bus.frame_n && frame_q_r;
  assign hit     = addr_ph && m_st == M_IDLE && bus.ad[31:4] == HOST_WIN
                   && (bus.cbe == CMD_MEM_RD || bus.cbe == CMD_MEM_WR);
  assign xfer    = !bus.irdy_n && !bus.trdy_n;
  assign m_go    = m_st == M_IDLE && go && t_st == T_IDLE && bus.frame_n && bus.irdy_n
                   && frame_q_r;
  assign m_end   = m_st == M_DATA && (!bus.stop_n || (xfer && m_left_r == 2'h0)
                   || (bus.devsel_n && m_cnt_r == MABORT_CYC));
  assign t_last  = t_st == T_DATA && xfer && bus.frame_n;
  assign rd_idx  = t_rdy_r ? t_idx_r + 2'h1 : t_idx_r;
  assign busy    = m_st != M_IDLE;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) frame_q_r <= 1'b1;
    else frame_q_r <= bus.frame_n;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Initiator
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      m_st <= M_IDLE; m_wr_r <= 1'b0; m_left_r <= 2'h0; m_idx_r <= 2'h0;
      m_cnt_r <= 3'h0; done_p <= 1'b0; err_r <= 1'b0; nwords_r <= 3'h0;
      rdata_r <= '0;
    end else begin
      done_p <= 1'b0;
      unique case (m_st)
        M_IDLE: if (m_go) begin
          m_st <= M_ADDR; m_wr_r <= write; m_left_r <= len; m_idx_r <= 2'h0;
          nwords_r <= 3'h0; err_r <= 1'b0;
        end
        M_ADDR: begin
          m_st <= M_DATA; m_cnt_r <= 3'h0;
        end
        M_DATA: begin
          if (!bus.devsel_n) m_cnt_r <= 3'h0;
          else m_cnt_r <= m_cnt_r + 3'h1;
          if (xfer) begin
            if (!m_wr_r) rdata_r[m_idx_r] <= bus.ad;
            m_idx_r <= m_idx_r + 2'h1; m_left_r <= m_left_r - 2'h1;
            nwords_r <= nwords_r + 3'h1;
          end
          if (m_end) begin
            m_st <= M_TURN; done_p <= 1'b1;
            err_r <= !xfer && (bus.devsel_n || !bus.stop_n);
          end
        end
        M_TURN: m_st <= M_IDLE;
      endcase
    end
  end

  // Frame held while more phases follow, dropped on the last one
  assign bus.host_frame_oe = m_st == M_ADDR || m_st == M_DATA || m_st == M_TURN;
  assign bus.host_frame_o  = !(m_st == M_ADDR || (m_st == M_DATA && m_left_r != 2'h0
                             && bus.stop_n));
  assign bus.host_irdy_oe  = m_st == M_DATA || m_st == M_TURN;
  assign bus.host_irdy_o   = m_st != M_DATA;
  assign bus.host_cbe_oe   = m_st == M_ADDR || m_st == M_DATA;
  assign bus.host_cbe_o    = cbe_r;

  ////////////////////////////////////////////////////////////////////////////
  // Target
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      t_st <= T_IDLE; t_wr_r <= 1'b0; t_idx_r <= 2'h0; t_rdy_r <= 1'b0; mem_r <= '0;
    end else begin
      unique case (t_st)
        T_IDLE: if (hit) begin
          t_st <= T_DATA; t_wr_r <= bus.cbe[0]; t_idx_r <= bus.ad[3:2];
          t_rdy_r <= bus.cbe[0];
        end
        T_DATA: begin
          if (!t_rdy_r) t_rdy_r <= 1'b1;
          else if (xfer) begin
            for (int b = 0; b < 4; b++)
              if (t_wr_r && !bus.cbe[b]) mem_r[t_idx_r][8*b +: 8] <= bus.ad[8*b +: 8];
            t_idx_r <= t_idx_r + 2'h1;
          end
          if (t_last) begin
            t_st <= T_TURN; t_rdy_r <= 1'b0;
          end
        end
        T_TURN: t_st <= T_IDLE;
        default: t_st <= T_IDLE;
      endcase
    end
  end

  assign bus.host_devsel_oe = t_st != T_IDLE;
  assign bus.host_devsel_o  = t_st == T_TURN;
  assign bus.host_trdy_oe   = t_st != T_IDLE;
  assign bus.host_trdy_o    = !(t_st == T_DATA && t_rdy_r);
  assign bus.host_stop_oe   = 1'b0;
  assign bus.host_stop_o    = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Address/data drive and parity
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ad_r <= '0; ad_oe_r <= 1'b0; cbe_r <= 4'hf;
    end else if (m_go) begin
      ad_r <= addr; ad_oe_r <= 1'b1; cbe_r <= write ? CMD_MEM_WR : CMD_MEM_RD;
    end else if (m_st == M_ADDR) begin
      ad_r <= wdata[0]; ad_oe_r <= m_wr_r; cbe_r <= be;
    end else if (m_st == M_DATA) begin
      if (xfer && m_wr_r) ad_r <= wdata[m_idx_r + 2'h1];
      if (m_end) ad_oe_r <= 1'b0;
    end else if (t_st == T_DATA && !t_wr_r) begin
      if (t_last) ad_oe_r <= 1'b0;
      else if (!t_rdy_r || xfer) begin
        ad_r <= mem_r[rd_idx]; ad_oe_r <= 1'b1;
      end
    end else begin
      ad_oe_r <= 1'b0;
    end
  end
  assign bus.host_ad_o  = ad_r;
  assign bus.host_ad_oe = ad_oe_r;

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      par_r <= 1'b0; par_oe_r <= 1'b0; chk_r <= 1'b0; dp_q_r <= 1'b0;
      perr_r <= 1'b0; perr_hi_r <= 1'b0;
    end else begin
      par_r     <= even_par(bus.ad, bus.cbe);
      par_oe_r  <= ad_oe_r || (m_st == M_ADDR);
      chk_r     <= even_par(bus.ad, bus.cbe);
      dp_q_r    <= xfer && !ad_oe_r && ((t_st == T_DATA && t_wr_r)
                   || (m_st == M_DATA && !m_wr_r));
      perr_r    <= dp_q_r && bus.par != chk_r;
      perr_hi_r <= perr_r;
    end
  end
  assign bus.host_par_o   = par_r;
  assign bus.host_par_oe  = par_oe_r;
  assign bus.host_perr_oe = perr_r || perr_hi_r;
  assign bus.host_perr_o  = !perr_r;

  assign irq_seen  = !bus.inta_n;
  assign serr_seen = !bus.serr_n;
  assign perr_seen = !bus.perr_n;
endmodule
`default_nettype wire

/* File: tb/pci_link_checker.sv */
// Concurrent checks on the bus between the agent end and the host end.
// Assumes resolved link wires plus the enables of both ends as inputs.
`timescale 1ns/100ps
`default_nettype none
module pci_link_checker (
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic [31:0] ad,
  input wire logic [3:0]  cbe,
  input wire logic        par,
  input wire logic        frame_n,
  input wire logic        irdy_n,
  input wire logic        trdy_n,
  input wire logic        devsel_n,
  input wire logic        stop_n,
  input wire logic        dev_ad_oe,
  input wire logic        host_ad_oe,
  input wire logic        dev_par_oe,
  input wire logic        host_par_oe,
  input wire logic        dev_serr_o,
  input wire logic        dev_serr_oe,
  input wire logic        dev_inta_o,
  input wire logic        dev_inta_oe
);
  import pci_pkg::*;
  wire hit = (ad[31:4] == DEV_WIN || ad[31:4] == HOST_WIN) &&
             (cbe == CMD_MEM_RD || cbe == CMD_MEM_WR);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence addr_ph;
    $fell(frame_n) && irdy_n;
  endsequence
  sequence last_done;
    !irdy_n && !trdy_n && frame_n;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  AST_PAR_EVEN: assert property ((dev_par_oe || host_par_oe) |->
    par == ^{$past(ad), $past(cbe)}) else $error("parity not even");
  AST_DEV_PAR: assert property (dev_ad_oe |=> dev_par_oe)
    else $error("agent parity not driven after ad");
  AST_HOST_PAR: assert property (host_ad_oe |=> host_par_oe)
    else $error("host parity not driven after ad");
  AST_PAR_DATA: assert property (!trdy_n |=> dev_par_oe || host_par_oe)
    else $error("data parity not driven after target ready");
  AST_CLAIM: assert property (addr_ph ##0 hit |=> !devsel_n)
    else $error("window access not claimed");
  AST_NO_CLAIM: assert property (addr_ph ##0 !hit |=> devsel_n [*5])
    else $error("foreign access claimed");
  AST_TRDY_SEL: assert property (!trdy_n |-> !devsel_n)
    else $error("target ready without select");
  AST_WAIT: assert property (!irdy_n && trdy_n && !devsel_n && stop_n |=> !irdy_n)
    else $error("initiator left wait cycle");
  AST_LAST: assert property (last_done |=> irdy_n && frame_n)
    else $error("bus not ended after final phase");
  AST_STOP: assert property ($fell(stop_n) |-> ##[0:1] frame_n)
    else $error("master ignored stop");
  AST_SERR_OD: assert property (dev_serr_oe |-> !dev_serr_o)
    else $error("system error driven high");
  AST_INTA_OD: assert property (dev_inta_oe |-> !dev_inta_o)
    else $error("interrupt driven high");
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Bench joining agent and host ends across one link, scenario tasks.
// Assumes both design ends and the link interface compiled before it.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pci_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic go = 1'b0, write = 1'b0, irq_req = 1'b0, mreq = 1'b0, mwrite = 1'b0;
  word_t addr = 32'h0, maddr = 32'h0, mwdata = 32'h0;
  word_t [3:0] wdata = 128'h0;
  logic [1:0] len = 2'h0;
  logic [3:0] be = 4'h0, mbe = 4'h0;
  logic busy, done_p, err_r, irq_seen, serr_seen, perr_seen;
  logic mbusy, mdone_r, merr_r, par_err_r;
  logic [2:0] nwords_r;
  word_t [3:0] rdata_r;
  word_t mrdata_r;
  int miscompares = 0, n_compared = 0, par_faults = 0;
  pci_link_if link ();
  pci_host u_pci_host (.bus(link), .ref_clk, .rstn, .go, .write, .addr, .len, .wdata, .be,
    .busy, .done_p, .err_r, .nwords_r, .rdata_r, .irq_seen, .serr_seen, .perr_seen);
  pci_agent u_pci_agent (.bus(link), .ref_clk, .rstn, .irq_req, .mreq, .mwrite, .maddr,
    .mwdata, .mbe, .mbusy, .mdone_r, .merr_r, .mrdata_r, .par_err_r);
  pci_link_checker u_pci_link_checker (.ref_clk, .rstn, .ad(link.ad), .cbe(link.cbe),
    .par(link.par), .frame_n(link.frame_n), .irdy_n(link.irdy_n), .trdy_n(link.trdy_n),
    .devsel_n(link.devsel_n), .stop_n(link.stop_n), .dev_ad_oe(link.dev_ad_oe),
    .host_ad_oe(link.host_ad_oe), .dev_par_oe(link.dev_par_oe),
    .host_par_oe(link.host_par_oe), .dev_serr_o(link.dev_serr_o),
    .dev_serr_oe(link.dev_serr_oe), .dev_inta_o(link.dev_inta_o),
    .dev_inta_oe(link.dev_inta_oe));
  always #12.5 ref_clk = ~ref_clk;
  // Any parity report is a fault, both ends drive parity correctly
  always @(negedge ref_clk)
    if (rstn && {par_err_r, perr_seen, serr_seen} !== 3'h0) par_faults++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask
  task automatic host_go(input logic w, input word_t a, input logic [1:0] l);
    int i;
    @(negedge ref_clk);
    write = w;
    addr = a;
    len = l;
    go = 1'b1;
    @(negedge ref_clk);
    go = 1'b0;
    chk("host busy", 32'h1, {31'h0, busy});
    for (i = 0; i < 60 && done_p !== 1'b1; i++) @(negedge ref_clk);
    chk("host done", 32'h1, {31'h0, done_p});
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic agent_go(input logic w, input word_t a, input word_t d);
    int i;
    @(negedge ref_clk);
    mwrite = w;
    maddr = a;
    mwdata = d;
    mreq = 1'b1;
    @(negedge ref_clk);
    mreq = 1'b0;
    chk("agent busy", 32'h1, {31'h0, mbusy});
    for (i = 0; i < 60 && mdone_r !== 1'b1; i++) @(negedge ref_clk);
    chk("agent done", 32'h1, {31'h0, mdone_r});
    repeat (2) @(negedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_agent_rw();
    agent_go(1'b1, 32'h00020004, 32'h5a5a1234);
    chk("agent write err", 32'h0, {31'h0, merr_r});
    agent_go(1'b0, 32'h00020004, 32'h0);
    chk("agent read data", 32'h5a5a1234, mrdata_r);
  endtask
  task automatic t_host_burst();
    int i;
    for (i = 0; i < 4; i++) wdata[i] = 32'h11110000 + i;
    host_go(1'b1, 32'h00010000, 2'h3);
    chk("burst words", 32'h4, {29'h0, nwords_r});
    for (i = 0; i < 4; i++) wdata[i] = 32'h22220000 + i;
    host_go(1'b1, 32'h00010008, 2'h3);
    chk("stopped words", 32'h2, {29'h0, nwords_r});
    chk("stopped err", 32'h0, {31'h0, err_r});
    // Single phase with only the two low byte lanes enabled
    wdata[0] = 32'h33333333;
    be = 4'hc;
    host_go(1'b1, 32'h00010000, 2'h0);
    be = 4'h0;
    chk("single words", 32'h1, {29'h0, nwords_r});
    host_go(1'b0, 32'h00010000, 2'h3);
    chk("masked word", 32'h11113333, rdata_r[0]);
    for (i = 1; i < 4; i++) chk("burst read", i < 2 ? 32'h11110000 + i : 32'h22220000 + i - 2,
      rdata_r[i]);
  endtask
  task automatic t_abort();
    agent_go(1'b0, 32'h00030000, 32'h0);
    chk("abort err", 32'h1, {31'h0, merr_r});
  endtask
  task automatic t_irq();
    irq_req = 1'b1;
    repeat (2) @(negedge ref_clk);
    chk("irq line", 32'h0, {31'h0, link.inta_n});
    irq_req = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk("irq released", 32'h0, {31'h0, irq_seen});
    chk("no parity fault", 32'h0, {30'h0, perr_seen, serr_seen});
    chk("parity faults", 32'h0, par_faults);
  endtask
  task automatic t_reset();
    @(negedge ref_clk);
    write = 1'b0;
    addr = 32'h00010000;
    go = 1'b1;
    repeat (2) @(negedge ref_clk);
    go = 1'b0;
    rstn = 1'b0;
    #1;
    chk("reset float", 32'h0, {29'h0, link.host_frame_oe, link.host_irdy_oe,
      link.dev_devsel_oe});
    chk("reset float stop", 32'h0, {30'h0, link.dev_stop_oe, link.host_cbe_oe});
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (2) @(negedge ref_clk);
  endtask
  initial begin
    #50000;
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    t_agent_rw();
    t_host_burst();
    t_abort();
    t_irq();
    t_reset();
    t_agent_rw();
    end_sim();
  end
endmodule
`default_nettype wire
